// >>> dv/regulator_plant.sv
`timescale 1ns/1ps
// ==========================================================
// output plant: below the good level while off, while the
// soft-start runs, or while the bench forces a droop
module regulator_plant (
    // regulator state from the block
    input  wire logic [3:0] drive_on,
    input  wire logic [3:0] ramping,
    // forced droop
    input  wire logic [3:0] droop,
    // comparator result
    output logic      [3:0] below_good
);
    assign below_good = ~drive_on | ramping | droop;
endmodule // regulator_plant

// >>> dv/supervise_assertions.sv
`timescale 1ns/1ps
`include "supervise_regs.svh"
module supervise_checker (
    // clock and reset
    input wire logic                  CLK,
    input wire logic                  RST,
    // controls and comparators
    input wire logic [`NUM_REG-1:0]   REG_ON,
    input wire logic [`NUM_REG-1:0]   FAULT_IRQ_UNMASK,
    input wire logic [`NUM_REG-1:0]   OUTPUT_BELOW_GOOD,
    input wire logic                  TEMP_WARNING,
    input wire logic                  TEMP_SHUTDOWN,
    input wire logic                  TEMP_COOLED,
    input wire logic                  BATTERY_BELOW,
    input wire logic [`BAT_SEL_W-1:0] BATTERY_THRESHOLD_SELECT,
    input wire logic                  BATTERY_IRQ_UNMASK,
    input wire logic                  THERMAL_IRQ_UNMASK,
    // outputs watched
    input wire logic [`NUM_REG-1:0]   REG_DRIVE_ON,
    input wire logic [`NUM_REG-1:0]   REG_RAMPING,
    input wire logic [`NUM_REG-1:0]   POWER_GOOD,
    input wire logic [`NUM_REG-1:0]   FAULT_PENDING,
    input wire logic                  BATTERY_LOW_FLAG,
    input wire logic [`MV_W-1:0]      BATTERY_THRESHOLD_MV,
    input wire logic                  THERMAL_LOCKOUT,
    input wire logic                  INTERRUPT_REQUEST_N_OE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // soft-start length, counted on regulator 0 only
    logic [12:0] ramp_cnt_q;
    always_ff @(posedge CLK) begin
        if (RST || !REG_RAMPING[0]) ramp_cnt_q <= 13'h0000;
        else ramp_cnt_q <= ramp_cnt_q + 13'h0001;
    end
    chk_ramp_len: assert property (
        $fell(REG_RAMPING[0]) && REG_DRIVE_ON[0]
        |-> ramp_cnt_q == 13'(`SOFT_START_CYC))
        else $error("soft-start length wrong");
    // ==========================================================
    // interrupt line, battery and thermal
    chk_irq_or: assert property (
        INTERRUPT_REQUEST_N_OE_N == !((|(FAULT_PENDING & FAULT_IRQ_UNMASK))
        || (TEMP_WARNING && THERMAL_IRQ_UNMASK)
        || (BATTERY_LOW_FLAG && BATTERY_IRQ_UNMASK)))
        else $error("interrupt line disagrees with sources");
    chk_bat_thr: assert property (!$past(RST) |->
        BATTERY_THRESHOLD_MV == 12'h9C4
        + 12'h064 * $past(BATTERY_THRESHOLD_SELECT))
        else $error("battery threshold wrong");
    chk_bat_flag: assert property (!$past(RST) |->
        BATTERY_LOW_FLAG == $past(BATTERY_BELOW))
        else $error("battery flag wrong");
    chk_shut_off: assert property (TEMP_SHUTDOWN |=>
        REG_DRIVE_ON == 4'h0 && THERMAL_LOCKOUT)
        else $error("shutdown left a regulator on");
    chk_lock_hold: assert property (
        THERMAL_LOCKOUT && !TEMP_COOLED
        |=> REG_DRIVE_ON == 4'h0 && THERMAL_LOCKOUT)
        else $error("enable accepted during lockout");
    // ==========================================================
    // per-regulator enable, power-good and fault
    for (genvar i = 0; i < `NUM_REG; i++) begin : g_reg
        chk_drive_start: assert property (
            $rose(REG_ON[i]) && !REG_DRIVE_ON[i] && !TEMP_SHUTDOWN
            && !THERMAL_LOCKOUT |=> REG_DRIVE_ON[i] && REG_RAMPING[i])
            else $error("enable did not start a ramp");
        chk_good_low: assert property (
            REG_RAMPING[i] || !REG_DRIVE_ON[i] |=> !POWER_GOOD[i])
            else $error("power good while off or ramping");
        chk_fault_set: assert property (
            POWER_GOOD[i] && OUTPUT_BELOW_GOOD[i] && REG_DRIVE_ON[i]
            && FAULT_IRQ_UNMASK[i] && REG_ON[i] && !TEMP_SHUTDOWN
            |=> FAULT_PENDING[i] && !POWER_GOOD[i])
            else $error("fault not latched on power loss");
        chk_fault_hold: assert property (
            FAULT_PENDING[i] && REG_RAMPING[i] && REG_ON[i]
            && !TEMP_SHUTDOWN |=> FAULT_PENDING[i])
            else $error("fault cleared while out of regulation");
    end
endmodule // supervise_checker

bind regulator_supervision_control supervise_checker i_chk (
    .CLK(CLK), .RST(RST), .REG_ON(REG_ON),
    .FAULT_IRQ_UNMASK(FAULT_IRQ_UNMASK),
    .OUTPUT_BELOW_GOOD(OUTPUT_BELOW_GOOD), .TEMP_WARNING(TEMP_WARNING),
    .TEMP_SHUTDOWN(TEMP_SHUTDOWN), .TEMP_COOLED(TEMP_COOLED),
    .BATTERY_BELOW(BATTERY_BELOW),
    .BATTERY_THRESHOLD_SELECT(BATTERY_THRESHOLD_SELECT),
    .BATTERY_IRQ_UNMASK(BATTERY_IRQ_UNMASK),
    .THERMAL_IRQ_UNMASK(THERMAL_IRQ_UNMASK),
    .REG_DRIVE_ON(REG_DRIVE_ON), .REG_RAMPING(REG_RAMPING),
    .POWER_GOOD(POWER_GOOD), .FAULT_PENDING(FAULT_PENDING),
    .BATTERY_LOW_FLAG(BATTERY_LOW_FLAG),
    .BATTERY_THRESHOLD_MV(BATTERY_THRESHOLD_MV),
    .THERMAL_LOCKOUT(THERMAL_LOCKOUT),
    .INTERRUPT_REQUEST_N_OE_N(INTERRUPT_REQUEST_N_OE_N)
);

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "supervise_regs.svh"
module tb;
    // ==========================================================
    // signals
    localparam logic [11:0] VBASE [8] = '{12'h258, 12'h320, 12'h3E8,
        12'h4B0, 12'h640, 12'h7D0, 12'h960, 12'hC80};
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [3:0] reg_on, flt_unm, wr_lo, wr_hi, pg_rd, droop, bat_sel;
    logic [3:0] drive_on, ramping, pgood, fault, below;
    logic [5:0] wdata, c;
    logic bank_pin, t_warn, t_shut, t_cool, bat_below, bat_unm, t_unm;
    logic bat_flag, lockout, oe_n, irq_o;
    logic [23:0] vcode;
    logic [47:0] tmv;
    logic [11:0] bat_mv;
    int err_total = 0;
    int compares = 0;
    int seed = 32'h800DE3A4;
    always #50 CLK = ~CLK;

    regulator_supervision_control i_dut (
        .CLK(CLK), .RST(RST), .REG_ON(reg_on), .FAULT_IRQ_UNMASK(flt_unm),
        .CODE_LOW_WR(wr_lo), .CODE_HIGH_WR(wr_hi), .CODE_WDATA(wdata),
        .VOLTAGE_BANK_SELECT_PIN(bank_pin), .POWER_GOOD_RD(pg_rd),
        .OUTPUT_BELOW_GOOD(below), .TEMP_WARNING(t_warn),
        .TEMP_SHUTDOWN(t_shut), .TEMP_COOLED(t_cool),
        .BATTERY_BELOW(bat_below), .BATTERY_THRESHOLD_SELECT(bat_sel),
        .BATTERY_IRQ_UNMASK(bat_unm), .THERMAL_IRQ_UNMASK(t_unm),
        .REG_DRIVE_ON(drive_on), .REG_RAMPING(ramping),
        .OUTPUT_VOLTAGE_CODE(vcode), .TARGET_MV(tmv), .POWER_GOOD(pgood),
        .FAULT_PENDING(fault), .BATTERY_LOW_FLAG(bat_flag),
        .BATTERY_THRESHOLD_MV(bat_mv), .THERMAL_LOCKOUT(lockout),
        .INTERRUPT_REQUEST_N_O(irq_o), .INTERRUPT_REQUEST_N_OE_N(oe_n));
    regulator_plant i_plant (.drive_on(drive_on), .ramping(ramping),
        .droop(droop), .below_good(below));

    // ==========================================================
    // expectations and helpers
    function automatic logic [11:0] exp_mv(input logic [5:0] v);
        logic [11:0] s;
        s = (v[5:3] < 3'h3) ? 12'h019 : (v[5:3] < 3'h6) ? 12'h032 : 12'h064;
        return VBASE[v[5:3]] + s * v[2:0];
    endfunction
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr_code(input logic hi, input int i, input logic [5:0] v);
        @(posedge CLK);
        wdata <= v;
        wr_hi <= hi ? 4'h1 << i : 4'h0;
        wr_lo <= hi ? 4'h0 : 4'h1 << i;
        @(posedge CLK);
        {wr_hi, wr_lo} <= 8'h00;
        tick(2);
    endtask
    // ramp is 4000 cycles; bound leaves margin
    task automatic wait_ramp();
        for (int n = 0; n < 5000; n++) begin
            if (ramping === 4'h0) return;
            @(negedge CLK);
        end
        err_total++;
        tally_and_finish();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {reg_on, flt_unm, wr_lo, wr_hi, pg_rd, droop, bat_sel} = '0;
        {wdata, bank_pin, t_warn, t_shut, t_cool} = '0;
        {bat_below, bat_unm, t_unm} = '0;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        tick(2);
        chk({bat_mv, oe_n}, {12'h9C4, 1'b1});
        for (int k = 0; k < 16; k++) begin
            @(posedge CLK) bat_sel <= 4'(k);
            tick(2);
            chk(bat_mv, 12'h9C4 + 12'h064 * 12'(k));
        end
        @(posedge CLK) bat_below <= 1'b1;
        tick(2);
        chk({bat_flag, oe_n}, 2'h3);
        @(posedge CLK) bat_unm <= 1'b1;
        tick(1);
        chk({irq_o, oe_n}, 2'h0);
        @(posedge CLK) bat_below <= 1'b0;
        tick(2);
        chk({bat_flag, oe_n}, 2'h1);
        // corners first: every range, then random codes
        for (int n = 0; n < 24; n++) begin
            c = (n < 8) ? {3'(n), 3'(n)} : 6'($random(seed));
            wr_code(1'b0, 0, c);
            chk(tmv[11:0], exp_mv(c));
        end
        // each bank is written only while the pin selects it
        for (int i = 1; i < 4; i++) begin
            c = 6'($random(seed));
            wr_code(1'b0, i, c);
            chk(vcode[6*i +: 6], c);
            chk(tmv[12*i +: 12], exp_mv(c));
            @(posedge CLK) bank_pin <= 1'b1;
            tick(1);
            wr_code(1'b1, i, ~c);
            chk(vcode[6*i +: 6], 6'(~c));
            @(posedge CLK) bank_pin <= 1'b0;
            tick(2);
            chk(vcode[6*i +: 6], c);
        end
        @(posedge CLK) reg_on <= 4'hF;
        tick(1);
        chk({drive_on, ramping}, 8'hFF);
        wait_ramp();
        tick(2);
        chk(pgood, 4'hF);
        @(posedge CLK);
        flt_unm <= 4'hF;
        droop <= 4'h4;
        tick(2);
        chk({fault, pgood, oe_n}, {4'h4, 4'hB, 1'b0});
        @(posedge CLK) droop <= 4'h0;
        wait_ramp();
        tick(2);
        chk({fault, pgood}, 8'h4F);
        @(posedge CLK) pg_rd <= 4'h4;
        @(posedge CLK) pg_rd <= 4'h0;
        tick(2);
        chk({fault, oe_n}, 5'h01);
        @(posedge CLK) t_warn <= 1'b1;
        tick(1);
        chk(oe_n, 1'b1);
        @(posedge CLK) t_unm <= 1'b1;
        tick(1);
        chk(oe_n, 1'b0);
        @(posedge CLK) t_warn <= 1'b0;
        @(posedge CLK) t_shut <= 1'b1;
        tick(2);
        chk({drive_on, lockout}, 5'h01);
        chk({fault, oe_n}, 5'h01);
        @(posedge CLK);
        t_shut <= 1'b0;
        reg_on <= 4'h0;
        @(posedge CLK) reg_on <= 4'hF;
        tick(3);
        chk({drive_on, lockout}, 5'h01);
        @(posedge CLK) t_cool <= 1'b1;
        tick(3);
        chk({drive_on, lockout}, 5'h1E);
        @(posedge CLK) reg_on <= 4'h0;
        tick(2);
        chk(drive_on, 4'h0);
        tally_and_finish();
    end
endmodule // tb

// >>> rtl/regulator_supervision_control.sv
`timescale 1ns/1ps
`include "supervise_regs.svh"

module regulator_supervision_control (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RST,
    // per-regulator control bits
    input  wire logic [`NUM_REG-1:0]   REG_ON,
    input  wire logic [`NUM_REG-1:0]   FAULT_IRQ_UNMASK,
    // stored codes: write strobes and data
    input  wire logic [`NUM_REG-1:0]   CODE_LOW_WR,
    input  wire logic [`NUM_REG-1:0]   CODE_HIGH_WR,
    input  wire logic [`CODE_W-1:0]    CODE_WDATA,
    input  wire logic                  VOLTAGE_BANK_SELECT_PIN,
    // power-good read strobe, one per regulator
    input  wire logic [`NUM_REG-1:0]   POWER_GOOD_RD,
    // analogue comparator results
    input  wire logic [`NUM_REG-1:0]   OUTPUT_BELOW_GOOD,
    input  wire logic                  TEMP_WARNING,
    input  wire logic                  TEMP_SHUTDOWN,
    input  wire logic                  TEMP_COOLED,
    input  wire logic                  BATTERY_BELOW,
    // battery monitor and thermal controls
    input  wire logic [`BAT_SEL_W-1:0] BATTERY_THRESHOLD_SELECT,
    input  wire logic                  BATTERY_IRQ_UNMASK,
    input  wire logic                  THERMAL_IRQ_UNMASK,
    // regulator drive
    output logic      [`NUM_REG-1:0]   REG_DRIVE_ON,
    output logic      [`NUM_REG-1:0]   REG_RAMPING,
    output logic      [`CODE_W*`NUM_REG-1:0] OUTPUT_VOLTAGE_CODE,
    output logic      [`MV_W*`NUM_REG-1:0]   TARGET_MV,
    // status
    output logic      [`NUM_REG-1:0]   POWER_GOOD,
    output logic      [`NUM_REG-1:0]   FAULT_PENDING,
    output logic                       BATTERY_LOW_FLAG,
    output logic      [`MV_W-1:0]      BATTERY_THRESHOLD_MV,
    output logic                       THERMAL_LOCKOUT,
    // open-drain interrupt: out is 0, enable low while driving
    output logic                       INTERRUPT_REQUEST_N_O,
    output logic                       INTERRUPT_REQUEST_N_OE_N
);
    logic [`NUM_REG-1:0] run;
    logic [`NUM_REG-1:0] restart;
    logic [`NUM_REG-1:0] good_q;
    logic [`NUM_REG-1:0] good_d;
    logic [`NUM_REG-1:0] fault_q;
    logic [`NUM_REG-1:0] read_done_q;
    logic [`NUM_REG-1:0] drive;
    logic                lockout_q;
    logic                batt_q;
    logic [`MV_W-1:0]    bat_mv_q;
    logic [`CODE_W-1:0]  code_lo_q [`NUM_REG];
    logic [`CODE_W-1:0]  code_hi_q [`NUM_REG];
    logic [`CODE_W-1:0]  code_act  [`NUM_REG];
    logic [`CODE_W*`NUM_REG-1:0] code_q;
    logic                irq;

    // ======================================================================
    // thermal shutdown lockout
    always_ff @(posedge CLK) begin
        if (RST) begin
            lockout_q <= 1'b0;
        end else if (TEMP_SHUTDOWN) begin
            lockout_q <= 1'b1;
        end else if (TEMP_COOLED) begin
            lockout_q <= 1'b0;
        end
    end

    // enable requests are refused while locked out
    assign run = REG_ON & {`NUM_REG{~lockout_q & ~TEMP_SHUTDOWN}};

    // ======================================================================
    // stored codes; software keeps the bank it writes in step with the pin
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < `NUM_REG; i++) begin
                code_lo_q[i] <= `CODE_RST;
                code_hi_q[i] <= `CODE_RST;
            end
        end else begin
            for (int i = 0; i < `NUM_REG; i++) begin
                if (CODE_LOW_WR[i]) begin
                    code_lo_q[i] <= CODE_WDATA;
                end
                if (CODE_HIGH_WR[i]) begin
                    code_hi_q[i] <= CODE_WDATA;
                end
            end
        end
    end

    // regulator 0 has a single code; the bank pin steers the rest
    always_comb begin
        for (int i = 0; i < `NUM_REG; i++) begin
            if (i >= `FIRST_BANKED && VOLTAGE_BANK_SELECT_PIN) begin
                code_act[i] = code_hi_q[i];
            end else begin
                code_act[i] = code_lo_q[i];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            code_q <= '0;
        end else begin
            for (int i = 0; i < `NUM_REG; i++) begin
                code_q[i*`CODE_W +: `CODE_W] <= code_act[i];
            end
        end
    end
    assign OUTPUT_VOLTAGE_CODE = code_q;

    // ======================================================================
    // per-regulator soft start and code decode
    genvar g;
    generate
        for (g = 0; g < `NUM_REG; g++) begin : g_reg
            soft_start_ramp u_ramp (
                .clk      (CLK),
                .rst      (RST),
                .run      (run[g]),
                .restart  (restart[g]),
                .drive_on (drive[g]),
                .ramping  (REG_RAMPING[g])
            );
            vcode_decode u_dec (
                .code       (code_q[g*`CODE_W +: `CODE_W]),
                .millivolts (TARGET_MV[g*`MV_W +: `MV_W])
            );
        end
    endgenerate
    assign REG_DRIVE_ON = drive;

    // ======================================================================
    // power-good and latched faults
    // a regulator that is off or still ramping is not counted as good
    assign good_d = drive & ~REG_RAMPING & ~OUTPUT_BELOW_GOOD;

    always_ff @(posedge CLK) begin
        if (RST) begin
            good_q <= '0;
        end else begin
            good_q <= good_d;
        end
    end
    assign POWER_GOOD = good_q;

    // a good-to-bad drop on a running regulator re-runs its ramp
    assign restart = good_q & ~good_d & run;

    always_ff @(posedge CLK) begin
        if (RST) begin
            fault_q     <= '0;
            read_done_q <= '0;
        end else begin
            for (int i = 0; i < `NUM_REG; i++) begin
                // a drop caused by switching off or lockout is no fault
                if (FAULT_IRQ_UNMASK[i] && restart[i]) begin
                    // a fresh fault beats a read in the same cycle
                    fault_q[i]     <= 1'b1;
                    read_done_q[i] <= 1'b0;
                end else if (fault_q[i]) begin
                    if (POWER_GOOD_RD[i]) begin
                        read_done_q[i] <= 1'b1;
                    end
                    if ((POWER_GOOD_RD[i] || read_done_q[i]) &&
                        (!run[i] || good_d[i])) begin
                        fault_q[i]     <= 1'b0;
                        read_done_q[i] <= 1'b0;
                    end
                end
            end
        end
    end
    assign FAULT_PENDING = fault_q;

    // ======================================================================
    // battery monitor
    always_ff @(posedge CLK) begin
        if (RST) begin
            bat_mv_q <= `BAT_BASE_MV;
            batt_q   <= 1'b0;
        end else begin
            bat_mv_q <= `BAT_BASE_MV + `MV_W'(`BAT_STEP_MV *
                        {8'h00, BATTERY_THRESHOLD_SELECT});
            batt_q   <= BATTERY_BELOW;
        end
    end
    assign BATTERY_THRESHOLD_MV = bat_mv_q;
    assign BATTERY_LOW_FLAG     = batt_q;
    assign THERMAL_LOCKOUT      = lockout_q;

    // ======================================================================
    // shared interrupt; the unmask inputs are expected low out of reset
    assign irq = (|(fault_q & FAULT_IRQ_UNMASK)) |
                 (batt_q & BATTERY_IRQ_UNMASK) |
                 (TEMP_WARNING & THERMAL_IRQ_UNMASK);

    assign INTERRUPT_REQUEST_N_O    = 1'b0;
    assign INTERRUPT_REQUEST_N_OE_N = RST | ~irq;

endmodule // regulator_supervision_control

// >>> rtl/soft_start_ramp.sv
`timescale 1ns/1ps
`include "supervise_regs.svh"

module soft_start_ramp (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic run,
    input  wire logic restart,
    // status
    output logic      drive_on,
    output logic      ramping
);
    supervise_pkg::ramp_state_t    state_q;
    logic [`RAMP_CNT_W-1:0]        cnt_q;
    localparam logic [`RAMP_CNT_W-1:0] LAST =
        `RAMP_CNT_W'(`SOFT_START_CYC - 1);

    // ======================================================================
    // ramp sequencing; a fault restart re-runs the full ramp
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            state_q <= supervise_pkg::RAMP_OFF;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                supervise_pkg::RAMP_OFF: begin
                    state_q <= supervise_pkg::RAMP_UP;
                    cnt_q   <= '0;
                end
                supervise_pkg::RAMP_UP: begin
                    if (cnt_q == LAST) begin
                        state_q <= supervise_pkg::RAMP_DONE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                supervise_pkg::RAMP_DONE: begin
                    if (restart) begin
                        state_q <= supervise_pkg::RAMP_UP;
                        cnt_q   <= '0;
                    end
                end
                default: begin
                    state_q <= supervise_pkg::RAMP_OFF;
                end
            endcase
        end
    end

    assign drive_on = (state_q != supervise_pkg::RAMP_OFF);
    assign ramping  = (state_q == supervise_pkg::RAMP_UP);

endmodule // soft_start_ramp

// >>> rtl/supervise_pkg.sv
package supervise_pkg;

    typedef enum logic [1:0] {
        RAMP_OFF  = 2'b00,
        RAMP_UP   = 2'b01,
        RAMP_DONE = 2'b11
    } ramp_state_t;

    typedef logic [5:0]  vcode_t;
    typedef logic [11:0] millivolt_t;

endpackage

// >>> rtl/supervise_regs.svh
`ifndef SUPERVISE_REGS_SVH
`define SUPERVISE_REGS_SVH

// ==========================================================================
// widths and counts
`define NUM_REG          4
`define CODE_W           6
`define MV_W             12
`define BAT_SEL_W        4
// ==========================================================================
// timing: soft-start ramp at a 10 MHz clock
`define CLK_PERIOD_NS    100
`define SOFT_START_US    400
`define SOFT_START_CYC   ((`SOFT_START_US * 1000) / `CLK_PERIOD_NS)
`define RAMP_CNT_W       13
// ==========================================================================
// battery threshold map, millivolts
`define BAT_BASE_MV      12'h9C4
`define BAT_STEP_MV      12'h064
// ==========================================================================
// voltage code map: range bases and steps in millivolts
`define RANGE_FIELD_MSB  5
`define RANGE_FIELD_LSB  3
`define STEP_FIELD_MSB   2
`define STEP_FIELD_LSB   0
`define VB0_MV           12'h258
`define VB1_MV           12'h320
`define VB2_MV           12'h3E8
`define VB3_MV           12'h4B0
`define VB4_MV           12'h640
`define VB5_MV           12'h7D0
`define VB6_MV           12'h960
`define VB7_MV           12'hC80
`define VSTEP_FINE_MV    12'h019
`define VSTEP_MID_MV     12'h032
`define VSTEP_COARSE_MV  12'h064
// ==========================================================================
// reset values and first banked regulator
`define EN_RST           4'h0
`define CODE_RST         6'h00
`define FIRST_BANKED     1

`endif

// >>> rtl/vcode_decode.sv
`timescale 1ns/1ps
`include "supervise_regs.svh"

module vcode_decode (
    // code in
    input  wire logic [`CODE_W-1:0] code,
    // target voltage out
    output logic      [`MV_W-1:0]   millivolts
);
    logic [2:0]       range;
    logic [2:0]       step;
    logic [`MV_W-1:0] base;
    logic [`MV_W-1:0] inc;

    assign range = code[`RANGE_FIELD_MSB:`RANGE_FIELD_LSB];
    assign step  = code[`STEP_FIELD_MSB:`STEP_FIELD_LSB];

    // ======================================================================
    // range base and step size
    always_comb begin
        case (range)
            3'h0: begin base = `VB0_MV; inc = `VSTEP_FINE_MV;   end
            3'h1: begin base = `VB1_MV; inc = `VSTEP_FINE_MV;   end
            3'h2: begin base = `VB2_MV; inc = `VSTEP_FINE_MV;   end
            3'h3: begin base = `VB3_MV; inc = `VSTEP_MID_MV;    end
            3'h4: begin base = `VB4_MV; inc = `VSTEP_MID_MV;    end
            3'h5: begin base = `VB5_MV; inc = `VSTEP_MID_MV;    end
            3'h6: begin base = `VB6_MV; inc = `VSTEP_COARSE_MV; end
            3'h7: begin base = `VB7_MV; inc = `VSTEP_COARSE_MV; end
            default: begin
                base = `VB0_MV;
                inc  = `VSTEP_FINE_MV;
            end
        endcase
    end

    // product fits: largest is 7 * 100 mV
    assign millivolts = base + `MV_W'(inc * {9'h000, step});

endmodule // vcode_decode
